// ==== hdl/fisl_pkg.sv ====
// shared constants and types for the fast isolated serial link
package fisl_pkg;

  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int unsigned FRAME_BITS    = 10;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned CHAN_BIT_POS  = 9;
  localparam logic        START_BIT_VAL = 1'b0;
  localparam logic        IDLE_LINE_VAL = 1'b1;
  localparam logic        CHAN_A_VAL    = 1'b0;
  localparam logic        CHAN_B_VAL    = 1'b1;

  // ----------------------------------------
  // bit-mode command values
  // ----------------------------------------
  localparam logic [7:0]  MODE_HOLD_RESET = 8'h0a;
  localparam logic [7:0]  MODE_RELEASE    = 8'h00;

  // ----------------------------------------
  // counters and dividers
  // ----------------------------------------
  localparam logic [3:0]  CNT_LAST     = 4'h9;
  // last receive count: eight data bits then the channel bit
  localparam logic [3:0]  CNT_RX_LAST  = 4'h8;
  localparam logic [3:0]  CNT_ZERO     = 4'h0;
  localparam logic [3:0]  HALF_PERIOD  = 4'h4;

  // ----------------------------------------
  // link state
  // ----------------------------------------
  typedef enum logic [1:0] {
    FISL_IDLE = 2'b00,
    FISL_TX   = 2'b01,
    FISL_RX   = 2'b10
  } fisl_state_type;

endpackage : fisl_pkg

// ==== hdl/fisl_link_if.sv ====
// link wires between the device end and the external end
`timescale 1ns/100ps
interface fisl_link_if;
  logic link_clock_in;
  logic serial_in_line;
  logic serial_out_line;
  logic clear_to_send_out;

  modport device (
    input  link_clock_in,
    input  serial_in_line,
    output serial_out_line,
    output clear_to_send_out
  );

  modport ext (
    output link_clock_in,
    output serial_in_line,
    input  serial_out_line,
    input  clear_to_send_out
  );
endinterface : fisl_link_if

// ==== hdl/fisl_device.sv ====
// device end: frames bytes from two channels onto the link
`timescale 1ns/100ps

// Contract
// - outgoing frames only advance on link clock
// - ready byte starts frame with low output
// - no outgoing frame during a reception
// - every start bit is zero
// - start, eight data lsb first, channel
// - outgoing channel bit: A zero, B one
// - external party stops clock when busy
// - external sends only while clear-to-send high
// - start bit drops clear-to-send next edge
// - clear-to-send low until byte accepted
// - channel bit routes, fallback to other channel
// - logic disabled unless a channel enabled
// - simultaneous start: receive, abandon own send
// - mode value ten holds serial reset
// - mode value zero releases the hold
// - pins always on channel B interface
// - pins change only on external clock edges; hold or no enabled channel forces out high and clear-to-send low on any clk
// - data moves one direction at a time
module fisl_device
  import fisl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // configuration
  input  wire logic       chan_a_en,
  input  wire logic       chan_b_en,
  input  wire logic [7:0] bit_mode,
  input  wire logic       bit_mode_we,
  // channel a transmit byte
  input  wire logic       a_tx_valid,
  input  wire logic [7:0] a_tx_data,
  output logic            a_tx_ready,
  // channel b transmit byte
  input  wire logic       b_tx_valid,
  input  wire logic [7:0] b_tx_data,
  output logic            b_tx_ready,
  // received bytes
  output logic            a_rx_valid,
  output logic            b_rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       a_rx_ready,
  input  wire logic       b_rx_ready,
  // link, always on the channel b pins
  fisl_link_if.device     link
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [1:0] clk_s_q, clk_s_d;
  logic [1:0] din_s_q, din_s_d;
  logic       clk_prev_q, clk_prev_d;
  logic       rise;

  always_comb begin
    clk_s_d    = {clk_s_q[0], link.link_clock_in};
    din_s_d    = {din_s_q[0], link.serial_in_line};
    clk_prev_d = clk_s_q[1];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_s_q    <= 2'h0;
      din_s_q    <= 2'h3;
      clk_prev_q <= 1'b0;
    end else begin
      clk_s_q    <= clk_s_d;
      din_s_q    <= din_s_d;
      clk_prev_q <= clk_prev_d;
    end
  end

  assign rise = clk_s_q[1] & ~clk_prev_q;

  // ----------------------------------------
  // link engine
  // ----------------------------------------
  fisl_state_type state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [8:0]  tx_sh_q, tx_sh_d;
  logic [8:0]  rx_sh_q, rx_sh_d;
  logic [7:0]  rx_data_q, rx_data_d;
  logic        rx_full_q, rx_full_d;
  logic        rx_to_b_q, rx_to_b_d;
  logic        dout_q, dout_d;
  logic        cts_q, cts_d;
  logic        hold_q, hold_d;
  logic        enabled;
  logic        tx_pick_b;
  logic        tx_have;
  logic        take_a, take_b;
  logic        rx_drain;

  // only with a fast serial channel
  assign enabled   = chan_a_en | chan_b_en;
  assign tx_pick_b = b_tx_valid & chan_b_en;
  assign tx_have   = (a_tx_valid & chan_a_en) | tx_pick_b;
  assign rx_drain  = rx_full_q & (rx_to_b_q ? b_rx_ready : a_rx_ready);

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    tx_sh_d   = tx_sh_q;
    rx_sh_d   = rx_sh_q;
    rx_data_d = rx_data_q;
    rx_full_d = rx_full_q & ~rx_drain;
    rx_to_b_d = rx_to_b_q;
    dout_d    = dout_q;
    cts_d     = cts_q;
    hold_d    = hold_q;
    take_a    = 1'b0;
    take_b    = 1'b0;
    if (bit_mode_we && bit_mode == MODE_HOLD_RESET) begin
      hold_d = 1'b1;
    end else if (bit_mode_we && bit_mode == MODE_RELEASE) begin
      hold_d = 1'b0;
    end
    if (hold_q || !enabled) begin
      state_d = FISL_IDLE;
      cnt_d   = CNT_ZERO;
      dout_d  = IDLE_LINE_VAL;
      cts_d   = 1'b0;
    // otherwise the frame engine moves only on a link edge; rx_full_q still drains on any clk
    end else if (rise) begin
      case (state_q)
        FISL_IDLE: begin
          if (cts_q && din_s_q[1] == START_BIT_VAL) begin
            state_d = FISL_RX;
            cnt_d   = CNT_ZERO;
            cts_d   = 1'b0;
            dout_d  = IDLE_LINE_VAL;
          end else if (tx_have && dout_q == IDLE_LINE_VAL) begin
            state_d = FISL_TX;
            cnt_d   = CNT_ZERO;
            dout_d  = START_BIT_VAL;
            tx_sh_d = tx_pick_b ? {CHAN_B_VAL, b_tx_data} : {CHAN_A_VAL, a_tx_data};
            take_b  = tx_pick_b;
            take_a  = ~tx_pick_b;
          end else begin
            dout_d  = IDLE_LINE_VAL;
            cts_d   = ~rx_full_q | rx_drain;
          end
        end
        FISL_TX: begin
          if (cnt_q == CNT_LAST) begin
            state_d = FISL_IDLE;
            dout_d  = IDLE_LINE_VAL;
            cts_d   = ~rx_full_q | rx_drain;
          end else begin
            dout_d  = tx_sh_q[0];
            tx_sh_d = {1'b0, tx_sh_q[8:1]};
            cnt_d   = cnt_q + 4'h1;
          end
        end
        FISL_RX: begin
          rx_sh_d = {din_s_q[1], rx_sh_q[8:1]};
          cnt_d   = cnt_q + 4'h1;
          if (cnt_q == CNT_RX_LAST) begin
            state_d   = FISL_IDLE;
            rx_data_d = rx_sh_d[7:0];
            rx_full_d = 1'b1;
            rx_to_b_d = (rx_sh_d[8] == CHAN_B_VAL) ? chan_b_en : ~chan_a_en;
            cts_d     = 1'b0;
          end
        end
        default: state_d = FISL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= FISL_IDLE;
      cnt_q     <= CNT_ZERO;
      tx_sh_q   <= 9'h000;
      rx_sh_q   <= 9'h000;
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
      rx_to_b_q <= 1'b0;
      dout_q    <= 1'b1;
      cts_q     <= 1'b0;
      hold_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      tx_sh_q   <= tx_sh_d;
      rx_sh_q   <= rx_sh_d;
      rx_data_q <= rx_data_d;
      rx_full_q <= rx_full_d;
      rx_to_b_q <= rx_to_b_d;
      dout_q    <= dout_d;
      cts_q     <= cts_d;
      hold_q    <= hold_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // link pins only on channel b side
  assign link.serial_out_line   = dout_q;
  assign link.clear_to_send_out = cts_q;
  // byte leaves the source as the start bit goes out
  assign a_tx_ready = take_a;
  assign b_tx_ready = take_b;
  assign a_rx_valid = rx_full_q & ~rx_to_b_q;
  assign b_rx_valid = rx_full_q & rx_to_b_q;
  assign rx_data    = rx_data_q;

endmodule : fisl_device

// ==== hdl/fisl_ext.sv ====
// external end: makes the link clock and exchanges frames
`timescale 1ns/100ps
module fisl_ext
  import fisl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // byte to send into the device
  input  wire logic       send_valid,
  input  wire logic [7:0] send_data,
  input  wire logic       send_chan,
  output logic            send_ready,
  // byte received from the device
  output logic            recv_valid,
  output logic [7:0]      recv_data,
  output logic            recv_chan,
  input  wire logic       recv_ready,
  // link
  fisl_link_if.ext        link
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [1:0] dout_s_q, dout_s_d;
  logic [1:0] cts_s_q, cts_s_d;

  always_comb begin
    dout_s_d = {dout_s_q[0], link.serial_out_line};
    cts_s_d  = {cts_s_q[0], link.clear_to_send_out};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_s_q <= 2'h3;
      cts_s_q  <= 2'h0;
    end else begin
      dout_s_q <= dout_s_d;
      cts_s_q  <= cts_s_d;
    end
  end

  // ----------------------------------------
  // clock divider and frame engine
  // ----------------------------------------
  fisl_state_type state_q, state_d;
  logic [3:0] div_q, div_d;
  logic       sclk_q, sclk_d;
  logic [3:0] cnt_q, cnt_d;
  logic [8:0] sh_q, sh_d;
  logic       din_q, din_d;
  logic       rv_q, rv_d;
  logic [8:0] rbuf_q, rbuf_d;
  logic       run;
  logic       rise;
  logic       take;

  // clock stops while a received byte waits
  assign run  = ~rv_q;
  // act on our own rising edge; device output has settled since the last one
  assign rise = run & (div_q == HALF_PERIOD) & ~sclk_q;

  always_comb begin
    div_d   = div_q;
    sclk_d  = sclk_q;
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    din_d   = din_q;
    rv_d    = rv_q & ~recv_ready;
    rbuf_d  = rbuf_q;
    take    = 1'b0;
    if (run) begin
      if (div_q == HALF_PERIOD) begin
        div_d  = CNT_ZERO;
        sclk_d = ~sclk_q;
      end else begin
        div_d  = div_q + 4'h1;
      end
    end
    if (rise) begin
      case (state_q)
        FISL_IDLE: begin
          if (dout_s_q[1] == START_BIT_VAL) begin
            state_d = FISL_RX;
            cnt_d   = CNT_ZERO;
          end else if (send_valid && cts_s_q[1]) begin
            state_d = FISL_TX;
            cnt_d   = CNT_ZERO;
            din_d   = START_BIT_VAL;
            sh_d    = {send_chan, send_data};
            take    = 1'b1;
          end
        end
        FISL_TX: begin
          if (cnt_q == CNT_LAST) begin
            state_d = FISL_IDLE;
            din_d   = IDLE_LINE_VAL;
          end else begin
            din_d = sh_q[0];
            sh_d  = {1'b0, sh_q[8:1]};
            cnt_d = cnt_q + 4'h1;
          end
        end
        FISL_RX: begin
          sh_d  = {dout_s_q[1], sh_q[8:1]};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == CNT_RX_LAST) begin
            state_d = FISL_IDLE;
            rbuf_d  = sh_d;
            rv_d    = 1'b1;
          end
        end
        default: state_d = FISL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q   <= CNT_ZERO;
      sclk_q  <= 1'b0;
      state_q <= FISL_IDLE;
      cnt_q   <= CNT_ZERO;
      sh_q    <= 9'h000;
      din_q   <= 1'b1;
      rv_q    <= 1'b0;
      rbuf_q  <= 9'h000;
    end else begin
      div_q   <= div_d;
      sclk_q  <= sclk_d;
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      din_q   <= din_d;
      rv_q    <= rv_d;
      rbuf_q  <= rbuf_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // link clock from our own divider
  assign link.link_clock_in  = sclk_q;
  assign link.serial_in_line = din_q;
  assign send_ready = take;
  assign recv_valid = rv_q;
  assign recv_data  = rbuf_q[7:0];
  assign recv_chan  = rbuf_q[8];

endmodule : fisl_ext

// ==== test/fisl_props.sv ====
// link checker for the fast isolated serial link
`timescale 1ns/100ps
module fisl_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link wires
  input wire logic link_clock_in,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic clear_to_send_out
);
  // ------
  // helper state
  // ------
  logic       lc_q, in_q, out_q, rise;
  logic [3:0] since_q, txb_q, rxb_q;
  assign rise = link_clock_in & ~lc_q;
  // counts run two clk ahead of the device's own sync, so bounds are loose
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lc_q    <= 1'b0;
      in_q    <= 1'b1;
      out_q   <= 1'b1;
      since_q <= 4'hf;
      txb_q   <= 4'h0;
      rxb_q   <= 4'h0;
    end else begin
      lc_q    <= link_clock_in;
      in_q    <= serial_in_line;
      out_q   <= serial_out_line;
      since_q <= rise ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
      if (txb_q == 4'h0) begin
        txb_q <= {3'h0, out_q & ~serial_out_line & rxb_q == 4'h0};
      end else if (rise) begin
        txb_q <= (txb_q == 4'ha) ? 4'h0 : txb_q + 4'h1;
      end
      if (rxb_q == 4'h0) begin
        rxb_q <= {3'h0, in_q & ~serial_in_line & txb_q == 4'h0};
      end else if (rise) begin
        rxb_q <= (rxb_q == 4'ha) ? 4'h0 : rxb_q + 4'h1;
      end
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence tx_start_s;
    txb_q == 4'h0 && out_q && !serial_out_line;
  endsequence
  sequence tx_last_s;
    rise && txb_q == 4'ha;
  endsequence
  sequence rx_first_s;
    rise && rxb_q == 4'h1;
  endsequence
  out_sync_a: assert property ($changed(serial_out_line) |-> since_q < 4'h7)
    else $error("serial out moved away from a link edge");
  cts_sync_a: assert property ($rose(clear_to_send_out) |-> since_q < 4'h7)
    else $error("clear to send rose away from a link edge");
  start_low_a: assert property (tx_start_s |-> !serial_out_line [*5])
    else $error("start bit not held low");
  frame_end_a: assert property (tx_last_s |-> ##[1:8] serial_out_line)
    else $error("outgoing frame not ended after ten bits");
  rx_quiet_a: assert property (rxb_q > 4'h1 |-> serial_out_line)
    else $error("device sent during a reception");
  cts_drop_a: assert property (rx_first_s |-> ##[1:16] !clear_to_send_out)
    else $error("clear to send not dropped after start bit");
  cts_held_a: assert property (rxb_q > 4'h3 |-> !clear_to_send_out)
    else $error("clear to send rose within a frame");
  idle_out_a: assert property (txb_q == 4'h0 && since_q == 4'h7 |-> serial_out_line)
    else $error("serial out low while idle");
endmodule : fisl_props

// ==== test/fisl_tb_top.sv ====
// self-checking bench: device end and external end back to back
`timescale 1ns/100ps
module fisl_tb_top
  import fisl_pkg::*;
;
  // ------
  // design and link
  // ------
  logic       clk = 1'b0, arst_n = 1'b0, chan_a_en = 1'b1, chan_b_en = 1'b1, bit_mode_we = 1'b0;
  logic [7:0] bit_mode = 8'h00, a_tx_data = 8'h00, b_tx_data = 8'h00, send_data = 8'h00;
  logic       a_tx_valid = 1'b0, b_tx_valid = 1'b0, a_rx_ready = 1'b1, b_rx_ready = 1'b1;
  logic       send_valid = 1'b0, send_chan = 1'b0, recv_ready = 1'b1;
  logic       a_tx_ready, b_tx_ready, a_rx_valid, b_rx_valid, send_ready, recv_valid, recv_chan;
  logic [7:0] rx_data, recv_data;
  logic [8:0] dq[$], rq[$];
  int         error_cnt = 0, tests_run = 0;
  localparam logic [7:0] TXD [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c};
  localparam logic [2:0] ROUTE [4] = '{3'b110, 3'b111, 3'b010, 3'b101};
  always #2.5 clk = ~clk;
  fisl_link_if link ();
  fisl_device fisl_device_i (.clk, .arst_n, .chan_a_en, .chan_b_en, .bit_mode, .bit_mode_we, .a_tx_valid,
    .a_tx_data, .a_tx_ready, .b_tx_valid, .b_tx_data, .b_tx_ready, .a_rx_valid, .b_rx_valid, .rx_data,
    .a_rx_ready, .b_rx_ready, .link(link.device));
  // receiver stall is driven by t_halt so the clock halt is exercised
  fisl_ext fisl_ext_i (.clk, .arst_n, .send_valid, .send_data, .send_chan, .send_ready, .recv_valid,
    .recv_data, .recv_chan, .recv_ready, .link(link.ext));
  fisl_props fisl_props_i (.clk, .arst_n, .link_clock_in(link.link_clock_in),
    .serial_in_line(link.serial_in_line), .serial_out_line(link.serial_out_line),
    .clear_to_send_out(link.clear_to_send_out));
  always @(posedge clk) begin
    if (a_rx_valid === 1'b1 && a_rx_ready === 1'b1) dq.push_back({CHAN_A_VAL, rx_data});
    if (b_rx_valid === 1'b1 && b_rx_ready === 1'b1) dq.push_back({CHAN_B_VAL, rx_data});
    if (recv_valid === 1'b1 && recv_ready === 1'b1) rq.push_back({recv_chan, recv_data});
    if (a_tx_ready === 1'b1) a_tx_valid <= #1 1'b0;
    if (b_tx_ready === 1'b1) b_tx_valid <= #1 1'b0;
    if (send_ready === 1'b1) send_valid <= #1 1'b0;
  end
  // ------
  // tasks
  // ------
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic take(input bit dev, output logic [8:0] v);
    v = 9'hxxx;
    repeat (2000) if ((dev ? dq.size() : rq.size()) == 0) @(posedge clk);
    if (dev && dq.size() > 0) v = dq.pop_front();
    if (!dev && rq.size() > 0) v = rq.pop_front();
  endtask : take
  task automatic dev_send(input bit ch, input logic [7:0] d);
    @(posedge clk);
    #1;
    if (ch) b_tx_data = d;
    else a_tx_data = d;
    if (ch) b_tx_valid = 1'b1;
    else a_tx_valid = 1'b1;
  endtask : dev_send
  task automatic ext_send(input bit ch, input logic [7:0] d);
    @(posedge clk);
    #1;
    send_chan = ch;
    send_data = d;
    send_valid = 1'b1;
    repeat (400) if (send_valid) @(posedge clk);
  endtask : ext_send
  task automatic mode(input logic [7:0] m, input logic a, input logic b);
    @(posedge clk);
    #1;
    bit_mode = m;
    bit_mode_we = 1'b1;
    chan_a_en = a;
    chan_b_en = b;
    @(posedge clk);
    #1;
    bit_mode_we = 1'b0;
  endtask : mode
  // ------
  // scenarios
  // ------
  task automatic t_tx();
    logic [8:0] v;
    for (int i = 0; i < 4; i++) begin
      dev_send(i[0], TXD[i]);
      take(1'b0, v);
      chk("outgoing frame", {i[0] ? CHAN_B_VAL : CHAN_A_VAL, TXD[i]}, v);
    end
  endtask : t_tx
  task automatic t_rx();
    logic [8:0] v;
    logic [2:0] r;
    for (int i = 0; i < 4; i++) begin
      r = ROUTE[i];
      mode(MODE_RELEASE, r[2], r[1]);
      ext_send(r[0], TXD[i]);
      take(1'b1, v);
      chk("routed byte", {r[0] ? r[1] : ~r[2], TXD[i]}, v);
    end
    mode(MODE_RELEASE, 1'b1, 1'b1);
  endtask : t_rx
  task automatic t_stall();
    logic [8:0] v;
    b_rx_ready = 1'b0;
    ext_send(1'b1, 8'h11);
    ext_send(1'b1, 8'h22);
    #1;
    chk("second byte held", 9'h001, {8'h00, send_valid});
    chk("clear to send", 9'h000, {8'h00, link.clear_to_send_out});
    b_rx_ready = 1'b1;
    take(1'b1, v);
    chk("first byte", {CHAN_B_VAL, 8'h11}, v);
    take(1'b1, v);
    chk("second byte", {CHAN_B_VAL, 8'h22}, v);
  endtask : t_stall
  task automatic t_hold();
    logic [8:0] v;
    mode(MODE_HOLD_RESET, 1'b1, 1'b1);
    dev_send(1'b0, 8'h6e);
    repeat (400) @(posedge clk);
    chk("sent in hold", 9'h000, 9'(rq.size()));
    mode(MODE_RELEASE, 1'b1, 1'b1);
    take(1'b0, v);
    chk("sent on release", {CHAN_A_VAL, 8'h6e}, v);
  endtask : t_hold
  task automatic t_off();
    logic [8:0] v;
    mode(MODE_RELEASE, 1'b0, 1'b0);
    ext_send(1'b0, 8'h81);
    chk("taken while off", 9'h001, {8'h00, send_valid});
    mode(MODE_RELEASE, 1'b1, 1'b1);
    take(1'b1, v);
    chk("byte after enable", {CHAN_A_VAL, 8'h81}, v);
  endtask : t_off
  task automatic t_contend();
    logic [8:0] v;
    // let clear-to-send recover, then load both ends mid low phase
    repeat (20) @(posedge clk);
    @(negedge link.link_clock_in);
    @(posedge clk);
    #1;
    b_tx_data = 8'hc3;
    b_tx_valid = 1'b1;
    send_data = 8'h96;
    send_chan = CHAN_A_VAL;
    send_valid = 1'b1;
    take(1'b1, v);
    chk("incoming wins", {CHAN_A_VAL, 8'h96}, v);
    chk("own send deferred", 9'h000, 9'(rq.size()));
    take(1'b0, v);
    chk("own send after", {CHAN_B_VAL, 8'hc3}, v);
  endtask : t_contend
  task automatic t_halt();
    logic [8:0] v;
    logic       lc;
    logic       moved;
    moved = 1'b0;
    @(posedge clk);
    #1;
    recv_ready = 1'b0;
    dev_send(1'b0, 8'h5a);
    repeat (400) if (recv_valid !== 1'b1) @(posedge clk);
    dev_send(1'b1, 8'hc6);
    lc = link.link_clock_in;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (link.link_clock_in !== lc) moved = 1'b1;
    end
    chk("clock halted", 9'h000, {8'h00, moved});
    chk("held byte kept", 9'h001, {8'h00, b_tx_valid});
    recv_ready = 1'b1;
    take(1'b0, v);
    chk("halted byte", {CHAN_A_VAL, 8'h5a}, v);
    take(1'b0, v);
    chk("byte after halt", {CHAN_B_VAL, 8'hc6}, v);
  endtask : t_halt
  // ------
  // run
  // ------
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    t_tx();
    t_rx();
    t_stall();
    t_hold();
    t_off();
    t_contend();
    t_halt();
    chk("stray bytes", 9'h000, 9'(dq.size() + rq.size()));
    tally_and_finish();
  end
  // whole run needs some 3k clocks; this leaves wide margin
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : fisl_tb_top
